/* inc/pscc_pkg.sv */
// pscc_pkg: constants for the pll setup clock configuration block
// assumes a byte-wide register port and a single 125 MHz system clock
package pscc_pkg;
    // register addresses
    localparam logic [7:0] ADDR_BYTE0 = 8'hD5;
    localparam logic [7:0] ADDR_BYTE1 = 8'hD6;
    localparam logic [7:0] ADDR_BYTE2 = 8'hD7;
    localparam logic [7:0] ADDR_BYTE3 = 8'hDB;
    localparam logic [7:0] ADDR_BYTE4 = 8'hDD;
    localparam logic [7:0] ADDR_STATUS = 8'hDE;
    localparam logic [7:0] ADDR_MASK = 8'hDF;
    // reset values
    localparam logic [7:0] RST_BYTE0 = 8'h2C;
    localparam logic [7:0] RST_BYTE1 = 8'h01;
    localparam logic [7:0] RST_BYTE2 = 8'h00;
    localparam logic [7:0] RST_BYTE3 = 8'h02;
    localparam logic [7:0] RST_BYTE4 = 8'h08;
    localparam logic [2:0] RST_MASK = 3'h0;
    // field positions in the top byte
    localparam int B4_BUSY = 7;
    localparam int B4_STEP_HI = 6;
    localparam int B4_STEP_LO = 3;
    localparam int B4_PREDIV_HI = 1;
    localparam int B4_PREDIV_LO = 0;
    // field positions in the fourth byte
    localparam int B3_LIMIT_HI = 2;
    localparam int B3_LIMIT_LO = 1;
    localparam int B3_ORIGIN = 0;
    // field positions in the third byte
    localparam int B2_BYPASS = 7;
    localparam int B2_CPUDIV_HI = 6;
    localparam int B2_CPUDIV_LO = 4;
    localparam int B2_SYSSEL_HI = 2;
    localparam int B2_SYSSEL_LO = 0;
    // status and mask bit positions
    localparam int ST_APPLIED = 0;
    localparam int ST_LOCKED = 1;
    localparam int ST_UNLOCKED = 2;
    localparam int ST_W = 3;
    // lock limit arithmetic
    localparam logic [4:0] LOCK_BASE = 5'h08;
    // settle time after a write, and its count of clock cycles
    localparam int CLK_FREQ_MHZ = 125;
    localparam int APPLY_TIME_NS = 64;
    localparam int APPLY_CYC = (APPLY_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int APPLY_W = $clog2(APPLY_CYC + 1);
    // divider width for reference and system selections
    localparam int DIV_W = 10;

    // reference pre-divider value, 1 when bypassed
    function automatic logic [DIV_W-1:0] pscc_ref_div(input logic [1:0] sel, input logic bypass);
        logic [DIV_W-1:0] v;
        v = 10'h200 >> sel;
        return bypass ? 10'h001 : v;
    endfunction : pscc_ref_div

    // divider on the 1 MHz oscillator for system clock codes 3..7
    function automatic logic [DIV_W-1:0] pscc_sys_div(input logic [2:0] sel);
        logic [DIV_W-1:0] v;
        v = 10'h001;
        case (sel)
            3'h3: v = 10'h008;
            3'h4: v = 10'h010;
            3'h5: v = 10'h020;
            3'h6: v = 10'h040;
            3'h7: v = 10'h100;
            default: v = 10'h001;
        endcase
        return v;
    endfunction : pscc_sys_div

    // cpu divider, reserved code 7 held at divide by 7
    function automatic logic [2:0] pscc_cpu_div(input logic [2:0] code);
        return (code == 3'h7) ? 3'h7 : code + 3'h1;
    endfunction : pscc_cpu_div

    // lock limit in reference cycles
    function automatic logic [4:0] pscc_lock_limit(input logic [1:0] lim);
        return {1'b0, lim, 2'b00} + LOCK_BASE;
    endfunction : pscc_lock_limit
endpackage : pscc_pkg

/* hdl/pscc_tick_div.sv */
// pscc_tick_div: divides a stream of one-cycle ticks by a programmable value
// assumes tick_i is a one-cycle pulse synchronous to clk_sys_i
`timescale 1ns/100ps
module pscc_tick_div
    import pscc_pkg::*;
#(
    parameter int WIDTH = DIV_W
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // ticks
    input wire logic tick_i,
    input wire logic [WIDTH-1:0] div_i,
    output logic tick_o
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic tick;
    } pscc_div_s;

    pscc_div_s st;
    pscc_div_s next_st;
    logic [WIDTH:0] h_seen;

    // count input ticks, emit one every div_i of them
    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (tick_i) begin
            if ({1'b0, st.cnt} + 1'b1 >= {1'b0, div_i}) begin
                next_st.cnt = '0;
                next_st.tick = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 1'b1;
            end
        end
    end

    // state register, frozen while ce_i is low
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign tick_o = st.tick;

    // helper: input ticks seen since the last output tick
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            h_seen <= '0;
        end else if (ce_i && tick_i) begin
            h_seen <= next_st.tick ? '0 : h_seen + 1'b1;
        end
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    div_period_a: assert property (
        (ce_i && tick_i && $stable(div_i) && div_i != '0 && next_st.tick)
            |-> (h_seen + 1'b1 >= {1'b0, div_i}))
        else $error("divider emitted at wrong tick count");
endmodule : pscc_tick_div

/* hdl/pscc_core.sv */
// pscc_core: 40-bit pll setup register with busy flag, clock selection and lock detect
// assumes ticks and strobes are synchronous to clk_sys_i; the pll analog core is outside
// Overview of operation
// - the setup is one 40-bit value; top byte holds busy, lock step, pre-divider select
// - any write to a setup byte sets the read-only busy flag in top bit
// - busy clears by itself once the new setup has been applied
// - lock is declared when in-range reference cycles reach limit times four plus eight
// - reference comes from the crystal when origin bit is zero, else 1 MHz oscillator
// - bypass bit one skips the pre-divider, zero applies the selected division
// - cpu clock is system clock divided by code plus one; code 111 unused
// - all 40 bits take effect together only on a write to the top byte
// - system clock code picks oscillator, crystal, pll, or oscillator divided 8..256
// - pll system clock is reference times multiplier over the pre-divider unless bypassed
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
module pscc_core
    import pscc_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // interrupt
    output logic irq_o,
    // clock source ticks and pll feedback
    input wire logic crystal_pins_tick_i,
    input wire logic osc_tick_i,
    input wire logic pll_tick_i,
    input wire logic pll_in_range0_i,
    // derived clocks and status
    output logic ref_div_tick_o,
    output logic sys_clk_tick_o,
    output logic cpu_clk_tick_o,
    output logic pll_locked_o,
    output logic pll_update_pending_o,
    // applied setup towards the pll core
    output logic [15:0] pll_multiplier_o,
    output logic [3:0] lock_step_sel_low_o,
    output logic ref_origin_sel_o,
    output logic [2:0] system_clock_select_o
);
    typedef struct packed {
        logic [7:0] b0;
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] b3;
        logic [7:0] b4;
        logic [39:0] active;
        logic busy;
        logic [APPLY_W-1:0] apply_cnt;
        logic [4:0] lock_cnt;
        logic locked;
        logic [ST_W-1:0] status;
        logic [ST_W-1:0] mask;
        logic [7:0] rdata;
    } pscc_state_s;

    pscc_state_s st;
    pscc_state_s next_st;
    logic [ST_W-1:0] ev;
    logic wr_hit;
    logic top_wr;
    logic [7:0] a_b2;
    logic [7:0] a_b3;
    logic [7:0] a_b4;
    logic ref_tick;
    logic osc_div_tick;
    logic [4:0] limit;

    // applied setup bytes
    assign a_b2 = st.active[23:16];
    assign a_b3 = st.active[31:24];
    assign a_b4 = st.active[39:32];

    // reference origin select
    assign ref_tick = a_b3[B3_ORIGIN] ? osc_tick_i : crystal_pins_tick_i;

    // reference pre-divider, bypass forces divide by one
    pscc_tick_div #(.WIDTH(DIV_W)) u_ref_div (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .tick_i(ref_tick),
        .div_i(pscc_ref_div(a_b4[B4_PREDIV_HI:B4_PREDIV_LO], a_b2[B2_BYPASS])),
        .tick_o(ref_div_tick_o)
    );

    // oscillator divider for the slow system clock codes
    pscc_tick_div #(.WIDTH(DIV_W)) u_osc_div (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .tick_i(osc_tick_i),
        .div_i(pscc_sys_div(a_b2[B2_SYSSEL_HI:B2_SYSSEL_LO])),
        .tick_o(osc_div_tick)
    );

    // system clock source select
    always_comb begin
        unique case (a_b2[B2_SYSSEL_HI:B2_SYSSEL_LO])
            3'h0: sys_clk_tick_o = osc_tick_i;
            3'h1: sys_clk_tick_o = crystal_pins_tick_i;
            3'h2: sys_clk_tick_o = pll_tick_i;
            3'h3, 3'h4, 3'h5, 3'h6, 3'h7: sys_clk_tick_o = osc_div_tick;
        endcase
    end

    // cpu clock divider on the system clock
    pscc_tick_div #(.WIDTH(3)) u_cpu_div (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .tick_i(sys_clk_tick_o),
        .div_i(pscc_cpu_div(a_b2[B2_CPUDIV_HI:B2_CPUDIV_LO])),
        .tick_o(cpu_clk_tick_o)
    );

    assign limit = pscc_lock_limit(a_b3[B3_LIMIT_HI:B3_LIMIT_LO]);
    assign wr_hit = wr_i && (addr_i inside {ADDR_BYTE0, ADDR_BYTE1, ADDR_BYTE2, ADDR_BYTE3, ADDR_BYTE4});
    assign top_wr = wr_i && addr_i == ADDR_BYTE4;

    // next state: register writes, busy timer, lock detect, reads, status
    always_comb begin
        next_st = st;
        ev = '0;
        next_st.rdata = 8'h00;
        if (wr_i) begin
            case (addr_i)
                ADDR_BYTE0: next_st.b0 = wdata_i;
                ADDR_BYTE1: next_st.b1 = wdata_i;
                ADDR_BYTE2: next_st.b2 = wdata_i;
                ADDR_BYTE3: next_st.b3 = wdata_i;
                ADDR_BYTE4: begin
                    next_st.b4 = {1'b0, wdata_i[6:0]};
                    next_st.active = {1'b0, wdata_i[6:0], st.b3, st.b2, st.b1, st.b0};
                end
                ADDR_MASK: next_st.mask = wdata_i[ST_W-1:0];
                default: ;
            endcase
        end
        // busy flag and settle timer
        if (wr_hit) begin
            next_st.busy = 1'b1;
            next_st.apply_cnt = APPLY_W'(APPLY_CYC);
        end else if (st.busy) begin
            if (st.apply_cnt <= APPLY_W'(1)) begin
                next_st.busy = 1'b0;
                next_st.apply_cnt = '0;
                ev[ST_APPLIED] = 1'b1;
            end else begin
                next_st.apply_cnt = st.apply_cnt - 1'b1;
            end
        end
        // lock detect on divided reference cycles
        if (top_wr) begin
            next_st.lock_cnt = '0;
            next_st.locked = 1'b0;
            ev[ST_UNLOCKED] = st.locked;
        end else if (ref_div_tick_o) begin
            if (!pll_in_range0_i) begin
                next_st.lock_cnt = '0;
                next_st.locked = 1'b0;
                ev[ST_UNLOCKED] = st.locked;
            end else if (!st.locked) begin
                if (st.lock_cnt + 5'h01 >= limit) begin
                    next_st.locked = 1'b1;
                    next_st.lock_cnt = limit;
                    ev[ST_LOCKED] = 1'b1;
                end else begin
                    next_st.lock_cnt = st.lock_cnt + 5'h01;
                end
            end
        end
        // read data for the next cycle
        if (rd_i) begin
            case (addr_i)
                ADDR_BYTE0: next_st.rdata = st.b0;
                ADDR_BYTE1: next_st.rdata = st.b1;
                ADDR_BYTE2: next_st.rdata = st.b2;
                ADDR_BYTE3: next_st.rdata = st.b3;
                ADDR_BYTE4: next_st.rdata = {st.busy, st.b4[6:0]};
                ADDR_STATUS: next_st.rdata = {5'h00, st.status};
                ADDR_MASK: next_st.rdata = {5'h00, st.mask};
                default: next_st.rdata = 8'h00;
            endcase
        end
        // sticky status, a new event wins over the read clear
        next_st.status = ((rd_i && addr_i == ADDR_STATUS) ? '0 : st.status) | ev;
    end

    // state register, frozen while ce_i is low
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st <= '0;
            st.b0 <= RST_BYTE0;
            st.b1 <= RST_BYTE1;
            st.b2 <= RST_BYTE2;
            st.b3 <= RST_BYTE3;
            st.b4 <= RST_BYTE4;
            st.active <= {RST_BYTE4, RST_BYTE3, RST_BYTE2, RST_BYTE1, RST_BYTE0};
            st.mask <= RST_MASK;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    // outputs
    assign rdata_o = st.rdata;
    assign irq_o = |(st.status & st.mask);
    assign pll_locked_o = st.locked;
    assign pll_update_pending_o = st.busy;
    assign pll_multiplier_o = st.active[15:0];
    assign lock_step_sel_low_o = a_b4[B4_STEP_HI:B4_STEP_LO];
    assign ref_origin_sel_o = a_b3[B3_ORIGIN];
    assign system_clock_select_o = a_b2[B2_SYSSEL_HI:B2_SYSSEL_LO];

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    busy_set_a: assert property ((ce_i && wr_hit) |=> pll_update_pending_o && st.apply_cnt == APPLY_CYC)
        else $error("busy not raised by setup write");

    busy_clear_a: assert property (
        (ce_i && st.busy && st.apply_cnt == 1 && !wr_hit) |=> !pll_update_pending_o && st.status[ST_APPLIED])
        else $error("busy did not clear after settle time");

    busy_hold_a: assert property (
        (ce_i && st.busy && st.apply_cnt > 1 && !wr_hit) |=> pll_update_pending_o)
        else $error("busy cleared early");

    stage_only_a: assert property (
        (wr_i && !top_wr) |=> $stable(st.active))
        else $error("setup applied without top byte write");

    apply_top_a: assert property (
        (ce_i && top_wr) |=> st.active[38:32] == $past(wdata_i[6:0]) && st.active[31:24] == $past(st.b3))
        else $error("top byte write did not apply setup");

    lock_rise_a: assert property ($rose(pll_locked_o) |-> $past(st.lock_cnt) + 5'h01 >= $past(limit))
        else $error("lock declared before limit reached");

    lock_drop_a: assert property (
        (ce_i && ref_div_tick_o && !pll_in_range0_i) |=> !pll_locked_o && st.lock_cnt == 0)
        else $error("lock kept while out of range");

    read_busy_a: assert property (
        (ce_i && rd_i && addr_i == ADDR_BYTE4) |=> rdata_o[B4_BUSY] == $past(st.busy))
        else $error("busy flag not readable");

    status_clear_a: assert property ((ce_i && rd_i && addr_i == ADDR_STATUS && ev == 0) |=> st.status == 0)
        else $error("status read did not clear");

    top_write_c: cover property (ce_i && top_wr ##[1:20] !pll_update_pending_o);
    lock_gain_c: cover property ($rose(pll_locked_o));
    irq_rise_c: cover property ($rose(irq_o));
endmodule : pscc_core

/* verif/pscc_core_tb.sv */
// pscc_core_tb: self-checking bench for the pll setup clock configuration block
// assumes pscc_pkg is compiled first; the bench drives the register port and all clock ticks
`timescale 1ns/100ps
module pscc_core_tb;
    import pscc_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic wr_i = 1'b0;
    logic ce = 1'b1;
    logic rd_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic [7:0] rdata_o;
    logic [7:0] rd_val;
    logic xtal = 1'b0, osc = 1'b0, pll = 1'b0, in_rng = 1'b0;
    logic ref_t, sys_t, cpu_t, locked, busy, irq_o, orig;
    logic [15:0] mult;
    logic [3:0] step;
    logic [2:0] ssel;
    int failures = 0;
    int checks = 0;
    int cyc = 0;
    int n;
    logic [7:0] addrs [5] = '{ADDR_BYTE0, ADDR_BYTE1, ADDR_BYTE2, ADDR_BYTE3, ADDR_BYTE4};
    logic [7:0] rsts [5] = '{RST_BYTE0, RST_BYTE1, RST_BYTE2, RST_BYTE3, RST_BYTE4};
    int sys_exp [8] = '{3, 2, 4, 24, 48, 96, 192, 768};

    // design under test, clock enable driven by the bench
    pscc_core u_pscc_core (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(ce),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .irq_o(irq_o), .crystal_pins_tick_i(xtal), .osc_tick_i(osc), .pll_tick_i(pll),
        .pll_in_range0_i(in_rng), .ref_div_tick_o(ref_t), .sys_clk_tick_o(sys_t),
        .cpu_clk_tick_o(cpu_t), .pll_locked_o(locked), .pll_update_pending_o(busy),
        .pll_multiplier_o(mult), .lock_step_sel_low_o(step), .ref_origin_sel_o(orig),
        .system_clock_select_o(ssel)
    );

    // 125 MHz system clock
    initial begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    // source ticks: crystal every 2 cycles, oscillator every 3, pll every 4
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        xtal <= (cyc % 2 == 1);
        osc <= (cyc % 3 == 0);
        pll <= (cyc % 4 == 0);
    end

    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask : wr

    // one-cycle read strobe, data taken in the following cycle
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        @(negedge clk_sys_i);
        rd_val = rdata_o;
    endtask : rd

    // poll the busy flag, counting the cycles it stays high
    task automatic idle(output int t);
        t = 0;
        @(negedge clk_sys_i);
        while (busy === 1'b1 && t < 100) begin
            t++;
            @(negedge clk_sys_i);
        end
    endtask : idle

    // write the upper bytes, finishing with the top byte, then clear status
    task automatic cfg(input logic [7:0] b2, input logic [7:0] b3, input logic [7:0] b4);
        int t;
        wr(ADDR_BYTE2, b2);
        idle(t);
        wr(ADDR_BYTE3, b3);
        idle(t);
        wr(ADDR_BYTE4, b4);
        idle(t);
        check(16'(t), 16'(APPLY_CYC));
        check(16'(irq_o), 16'h0000);
        rd(ADDR_STATUS);
    endtask : cfg

    // pick a derived tick
    function automatic logic tk(input int k);
        case (k)
            0: return ref_t;
            1: return sys_t;
            default: return cpu_t;
        endcase
    endfunction : tk

    // cycles between two ticks, skipping the first to drop a stale phase
    task automatic measure(input int k, output int n);
        int t;
        n = 0;
        t = 0;
        repeat (2) begin
            do begin
                @(negedge clk_sys_i);
                t++;
            end while (tk(k) !== 1'b1 && t < 6000);
        end
        do begin
            @(negedge clk_sys_i);
            n++;
        end while (tk(k) !== 1'b1 && n < 6000);
    endtask : measure

    // counts and verdict
    task automatic results;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    // hang guard
    initial begin
        repeat (60000) @(posedge clk_sys_i);
        failures++;
        $display("watchdog expired");
        results;
    end

    // test sequence
    initial begin
        repeat (6) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        check(mult, 16'h012C);
        check(16'(busy), 16'h0000);
        for (int i = 0; i < 5; i++) begin
            rd(addrs[i]);
            check(16'(rd_val), 16'(rsts[i]));
        end
        rd(8'hA0);
        check(16'(rd_val), 16'h0000);
        $display("test reset done");
        // lower bytes only stage
        wr(ADDR_BYTE0, 8'h40);
        idle(n);
        check(16'(n), 16'(APPLY_CYC));
        check(mult, 16'h012C);
        wr(ADDR_BYTE1, 8'h16);
        idle(n);
        check(mult, 16'h012C);
        rd(ADDR_BYTE0);
        check(16'(rd_val), 16'h0040);
        wr(ADDR_MASK, 8'h01);
        wr(ADDR_BYTE4, 8'h93);
        rd(ADDR_BYTE4);
        check(16'(rd_val), 16'h0093);
        check(mult, 16'h1640);
        check(16'(step), 16'h0002);
        idle(n);
        check(16'(irq_o), 16'h0001);
        rd(ADDR_STATUS);
        check(16'(rd_val), 16'h0001);
        check(16'(irq_o), 16'h0000);
        rd(ADDR_BYTE4);
        check(16'(rd_val), 16'h0013);
        wr(ADDR_MASK, 8'h00);
        // a write while the clock enable is low must be ignored
        @(posedge clk_sys_i);
        ce <= 1'b0;
        wr(ADDR_BYTE0, 8'h55);
        @(negedge clk_sys_i);
        check(16'(busy), 16'h0000);
        @(posedge clk_sys_i);
        ce <= 1'b1;
        rd(ADDR_BYTE0);
        check(16'(rd_val), 16'h0040);
        $display("test staging done");
        // reference division per select, origin and bypass
        for (int s = 0; s < 4; s++) begin
            cfg(8'h01, 8'h02, 8'(8'h10 | s));
            measure(0, n);
            check(16'(n), 16'(2 * (512 >> s)));
        end
        cfg(8'h01, 8'h03, 8'h13);
        measure(0, n);
        check(16'(n), 16'd192);
        check(16'(orig), 16'h0001);
        cfg(8'h81, 8'h03, 8'h13);
        measure(0, n);
        check(16'(n), 16'd3);
        cfg(8'h81, 8'h02, 8'h13);
        measure(0, n);
        check(16'(n), 16'd2);
        $display("test reference done");
        // system clock codes
        for (int c = 0; c < 8; c++) begin
            cfg(8'(c), 8'h02, 8'h13);
            measure(1, n);
            check(16'(n), 16'(sys_exp[c]));
            check(16'(ssel), 16'(c));
        end
        // cpu divider codes on the crystal system clock
        for (int c = 0; c < 7; c++) begin
            cfg({1'b0, 3'(c), 4'h1}, 8'h02, 8'h13);
            measure(2, n);
            check(16'(n), 16'(2 * (c + 1)));
        end
        $display("test clocks done");
        // lock limit, gain and loss
        for (int l = 0; l < 4; l++) begin
            @(posedge clk_sys_i);
            in_rng <= 1'b0;
            cfg(8'h81, {5'h00, 2'(l), 1'b0}, 8'h13);
            @(posedge clk_sys_i);
            in_rng <= 1'b1;
            n = 0;
            do begin
                @(negedge clk_sys_i);
                if (locked !== 1'b1 && ref_t === 1'b1) n++;
            end while (locked !== 1'b1 && n < 40);
            check(16'(n), 16'(4 * l + 8));
            rd(ADDR_STATUS);
            check(16'(rd_val), 16'h0002);
            @(posedge clk_sys_i);
            in_rng <= 1'b0;
            repeat (6) @(negedge clk_sys_i);
            check(16'(locked), 16'h0000);
            rd(ADDR_STATUS);
            check(16'(rd_val), 16'h0004);
        end
        $display("test lock done");
        results;
    end
endmodule : pscc_core_tb
